// >>> dlf_defs.svh
`ifndef DLF_DEFS_SVH
`define DLF_DEFS_SVH

// ==========
// register map (byte addresses)
`define DLF_OFS_CTRL        8'h00
`define DLF_OFS_STATUS      8'h04
`define DLF_OFS_MASK        8'h08
`define DLF_OFS_STATE       8'h0c

// ==========
// control fields
`define DLF_CTRL_W          14
`define DLF_CTRL_RST        14'h0000

// ==========
// status / mask bit positions
`define DLF_ST_W            4
`define DLF_ST_CRC          0
`define DLF_ST_PAR          1
`define DLF_ST_STRB         2
`define DLF_ST_DONE         3
`define DLF_ST_RST          4'h0
`define DLF_MASK_RST        4'h0

// ==========
// burst shape and timing
`define DLF_BURST_LEN       4'h8
`define DLF_CRC_BEATS       4'h2
`define DLF_CRC_INIT        8'h00
`define DLF_CRC_POLY        8'h07
`define DLF_PCLK_NS         8
`define DLF_HALF_NS         80
`define DLF_HALF_CYC        (`DLF_HALF_NS / `DLF_PCLK_NS)

`endif

// >>> dlf_pkg.sv
package dlf_pkg;

    typedef enum logic [1:0] {
        DLF_X4  = 2'b00,
        DLF_X8  = 2'b01,
        DLF_X16 = 2'b10
    } dlf_org_t;

    typedef struct packed {
        logic [3:0] vref_lanes;
        logic       rtt_en;
        logic       vref_mon;
        logic       par_en;
        logic       crc_en;
        logic       tdqs_en;
        logic       dm_en;
        logic       rd_dbi;
        logic       wr_dbi;
        dlf_org_t   org;
    } dlf_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       be;
        logic [7:0] data;
    } dlf_beat_t;

    typedef enum logic [1:0] {
        WL_IDLE = 2'b00,
        WL_ARM  = 2'b01,
        WL_DATA = 2'b10
    } dlf_wl_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_PRE  = 2'b01,
        RD_DATA = 2'b10,
        RD_POST = 2'b11
    } dlf_rd_state_t;

endpackage

// >>> dlf_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser; stage one is read by stage two only
module dlf_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// >>> dlf_crc8.sv
`timescale 1ns/100ps
`default_nettype none
`include "dlf_defs.svh"

// per-lane crc accumulator, msb first, one byte per enable
module dlf_crc8 (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       en,
    input  wire logic [7:0] data,
    output var  logic [7:0] crc
);

    logic [7:0] next_crc;

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ `DLF_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_comb begin
        next_crc = crc;
        if (clear) begin
            next_crc = `DLF_CRC_INIT;
        end else if (en) begin
            next_crc = crc_step(crc, data);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc <= `DLF_CRC_INIT;
        end else begin
            crc <= next_crc;
        end
    end

endmodule

`default_nettype wire

// >>> dlf_lane_top.sv
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dlf_defs.svh"

// Behaviour
// [R1] the data bus is two-way and 4, 8 or 16 bits wide for the x4, x8 and x16 organisations.
// [R2] with write crc on, a crc code follows each write burst and the device takes it there.
// [R3] with the reference monitor on, the internal reference level appears on any of data bits 0 to 3.
// [R4] the controller should set termination to high impedance while the reference monitor is on.
// [R5] x8 has one inversion pin; in x16 the upper one covers bits 15 to 8 and the lower bits 7 to 0.
// [R6] x4 has no data bus inversion.
// [R7] read inversion (driven) and write inversion (sampled) are enabled independently.
// [R8] read strobes are edge aligned with data, write strobes centred in the data window.
// [R9] in x16 the lower strobe times bits 7 to 0 and the upper bits 15 to 8; otherwise one strobe.
// [R10] the strobe is a true/complement pair only, never single ended.
// [R11] address parity errors and write crc errors show on the alert output when enabled.
// [R12] in x8 with the termination strobe on, it gets the same termination as the data strobe.
// [R13] with the termination strobe off, the shared pin is the write mask and its complement is unused.
// [R14] the controller keeps the termination strobe off for x4 and x16.
// [R15] write masking exists only in x8 and x16.
// [R16] a beat whose mask is sampled low on either strobe edge is discarded.
// [R17] the alert output is low while an error is pending and high otherwise.
module dlf_lane_top
    import dlf_pkg::*;
#(
    parameter int HALF_CYC = `DLF_HALF_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    output var  logic                irq,
    input  wire logic [15:0]         dq_i,
    output var  logic [15:0]         dq_o,
    output var  logic [15:0]         dq_oe,
    input  wire logic [1:0]          dqs_t_i,
    input  wire logic [1:0]          dqs_c_i,
    output var  logic [1:0]          dqs_t_o,
    output var  logic [1:0]          dqs_c_o,
    output var  logic [1:0]          dqs_oe,
    input  wire logic [1:0]          dmdbi_n_i,
    output var  logic [1:0]          dmdbi_n_o,
    output var  logic [1:0]          dmdbi_n_oe,
    output var  logic                tdqs_c_o,
    output var  logic                tdqs_c_oe,
    output var  logic                alert_n,
    input  wire logic                odt,
    output var  logic                term_dq,
    output var  logic [1:0]          term_dqs,
    output var  logic                term_tdqs,
    input  wire logic                wr_start,
    input  wire logic                par_err,
    input  wire logic [3:0]          vref_level,
    output var  dlf_beat_t [1:0]     wr_beat,
    input  wire logic                rd_start,
    input  wire logic [15:0]         rd_data,
    output var  logic                rd_take,
    output var  logic                rd_busy
);

    // ==========
    // pin synchronisers
    logic [22:0]              pin_s;
    logic [15:0]              s_dq;
    logic [1:0]               s_t;
    logic [1:0]               s_c;
    logic [1:0]               s_dm;
    logic                     s_odt;

    // dq shares the strobe's two flops, so a centred strobe edge lands inside the data window
    dlf_sync #(.W(23)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({odt, dmdbi_n_i, dqs_c_i, dqs_t_i, dq_i}),
        .q       (pin_s)
    );
    assign {s_odt, s_dm, s_c, s_t, s_dq} = pin_s;

    // ==========
    // helpers
    function automatic logic [15:0] dq_mask(input dlf_org_t o);
        case (o)
            DLF_X4:  dq_mask = 16'h000f;
            DLF_X8:  dq_mask = 16'h00ff;
            default: dq_mask = 16'hffff;
        endcase
    endfunction

    function automatic logic [8:0] dbi_enc(input logic [7:0] b);
        int zeros;
        zeros = 0;
        for (int i = 0; i < 8; i++) begin
            zeros = zeros + int'(!b[i]);
        end
        dbi_enc = (zeros > 4) ? {1'b0, ~b} : {1'b1, b};
    endfunction

    // ==========
    // registers
    dlf_ctrl_t                ctrl;
    logic [`DLF_ST_W-1:0]     status;
    logic [`DLF_ST_W-1:0]     mask;
    logic [`DLF_ST_W-1:0]     next_status;
    logic [`DLF_ST_W-1:0]     events;
    dlf_ctrl_t                next_ctrl;
    logic [`DLF_ST_W-1:0]     next_mask;
    logic [31:0]              next_prdata;
    logic                     acc_wr;
    logic                     mapped;
    logic                     next_alert_n;

    logic                     x4;
    logic                     tdqs_eff;
    logic                     dm_eff;
    logic                     wdbi_eff;
    logic                     rdbi_eff;
    logic [1:0]               lane_on;

    assign x4       = (ctrl.org == DLF_X4);
    assign tdqs_eff = ctrl.tdqs_en && (ctrl.org == DLF_X8); // R14
    assign wdbi_eff = ctrl.wr_dbi && !x4; // R6
    assign rdbi_eff = ctrl.rd_dbi && !x4; // R6
    // the shared pin is the mask unless it is inversion or termination strobe
    assign dm_eff   = ctrl.dm_en && !x4 && !tdqs_eff && !ctrl.wr_dbi; // R13 R15
    assign lane_on  = {ctrl.org[1], 1'b1}; // R9

    assign mapped  = (paddr == `DLF_OFS_CTRL) || (paddr == `DLF_OFS_STATUS) ||
                     (paddr == `DLF_OFS_MASK) || (paddr == `DLF_OFS_STATE);
    assign acc_wr  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ==========
    // write lanes
    dlf_wl_state_t [1:0]      wl_state;
    dlf_wl_state_t [1:0]      next_wl_state;
    logic [1:0][3:0]          wl_beat;
    logic [1:0][3:0]          next_wl_beat;
    logic [1:0]               wl_prev_t;
    logic [1:0]               wl_bad;
    logic [1:0]               next_wl_bad;
    dlf_beat_t [1:0]          next_wr_beat;
    logic [1:0]               crc_clr;
    logic [1:0]               crc_en;
    logic [1:0][7:0]          crc_byte;
    logic [1:0][7:0]          crc_val;
    logic [1:0]               lane_end;
    logic [1:0]               lane_bad;
    logic [1:0]               strb_bad;

    for (genvar g = 0; g < 2; g++) begin : g_crc
        dlf_crc8 u_crc (
            .pclk    (pclk),
            .presetn (presetn),
            .clear   (crc_clr[g]),
            .en      (crc_en[g]),
            .data    (crc_byte[g]),
            .crc     (crc_val[g])
        );
    end

    always_comb begin
        logic [7:0] lb;
        logic [3:0] last;
        logic       go;
        lb            = 8'h00;
        last          = 4'h0;
        go            = 1'b0;
        next_wl_state = wl_state;
        next_wl_beat  = wl_beat;
        next_wl_bad   = wl_bad;
        next_wr_beat  = wr_beat;
        crc_clr       = '0;
        crc_en        = '0;
        crc_byte      = '0;
        lane_end      = '0;
        lane_bad      = '0;
        strb_bad      = '0;
        last = ctrl.crc_en ? (`DLF_BURST_LEN + `DLF_CRC_BEATS - 4'h1) : (`DLF_BURST_LEN - 4'h1);  // R2
        for (int l = 0; l < 2; l++) begin
            next_wr_beat[l].valid = 1'b0;
            lb = (l == 0) ? (x4 ? {4'h0, s_dq[3:0]} : s_dq[7:0]) : s_dq[15:8];     // R1 R9
            go = 1'b0;
            case (wl_state[l])
                WL_IDLE: begin
                    if (wr_start && lane_on[l]) begin
                        next_wl_state[l] = WL_ARM;
                        next_wl_beat[l]  = 4'h0;
                        next_wl_bad[l]   = 1'b0;
                        crc_clr[l]       = 1'b1;
                    end
                end
                WL_ARM: begin
                    // the first rising edge after the preamble carries beat 0
                    if (s_t[l] && !wl_prev_t[l]) begin
                        go               = 1'b1;
                        next_wl_state[l] = WL_DATA;
                    end
                end
                WL_DATA: begin
                    go = s_t[l] ^ wl_prev_t[l]; // R16
                end
                default: begin
                    next_wl_state[l] = WL_IDLE;
                end
            endcase
            if (wl_state[l] != WL_IDLE && s_t[l] == s_c[l]) begin
                strb_bad[l] = 1'b1; // R10
            end
            if (go) begin
                next_wl_beat[l] = wl_beat[l] + 4'h1;
                if (wl_beat[l] < `DLF_BURST_LEN) begin
                    crc_en[l]                = 1'b1;
                    crc_byte[l]              = lb;
                    next_wr_beat[l].valid    = 1'b1;
                    next_wr_beat[l].data     = (wdbi_eff && !s_dm[l]) ? ~lb : lb;  // R5 R7
                    next_wr_beat[l].be       = !(dm_eff && !s_dm[l]); // R16
                end else if (x4) begin
                    if (wl_beat[l] == `DLF_BURST_LEN) begin
                        next_wl_bad[l] = wl_bad[l] | (lb[3:0] != crc_val[l][3:0]); // R2
                    end else begin
                        next_wl_bad[l] = wl_bad[l] | (lb[3:0] != crc_val[l][7:4]); // R2
                    end
                end else if (wl_beat[l] == `DLF_BURST_LEN) begin
                    next_wl_bad[l] = wl_bad[l] | (lb != crc_val[l]); // R2
                end
                if (wl_beat[l] == last) begin
                    next_wl_state[l] = WL_IDLE;
                    lane_end[l]      = 1'b1;
                    lane_bad[l]      = next_wl_bad[l];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wl_state  <= '{WL_IDLE, WL_IDLE};
            wl_beat   <= '0;
            wl_prev_t <= '0;
            wl_bad    <= '0;
            wr_beat   <= '0;
        end else begin
            wl_state  <= next_wl_state;
            wl_beat   <= next_wl_beat;
            wl_prev_t <= s_t;
            wl_bad    <= next_wl_bad;
            wr_beat   <= next_wr_beat;
        end
    end

    // ==========
    // read path: strobe made by dividing pclk, data changes on each strobe edge
    dlf_rd_state_t            rd_state;
    dlf_rd_state_t            next_rd_state;
    logic [7:0]               rd_cnt;
    logic [7:0]               next_rd_cnt;
    logic [2:0]               rd_idx;
    logic [2:0]               next_rd_idx;
    logic [15:0]              next_dq_o;
    logic [15:0]              next_dq_oe;
    logic [1:0]               next_dqs_t;
    logic [1:0]               next_dqs_oe;
    logic [1:0]               next_dm_o;
    logic [1:0]               next_dm_oe;
    logic [8:0]               enc_lo;
    logic [8:0]               enc_hi;
    logic                     tick;

    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

    assign tick    = (rd_cnt == 8'h00);
    assign rd_take = tick && ((rd_state == RD_PRE) || (rd_state == RD_DATA && rd_idx != 3'h7));
    assign rd_busy = (rd_state != RD_IDLE);
    assign enc_lo  = rdbi_eff ? dbi_enc(rd_data[7:0]) : {1'b1, rd_data[7:0]};  // R7
    assign enc_hi  = rdbi_eff ? dbi_enc(rd_data[15:8]) : {1'b1, rd_data[15:8]};

    always_comb begin
        next_rd_state = rd_state;
        next_rd_cnt   = tick ? HALF_M1 : rd_cnt - 8'h01;
        next_rd_idx   = rd_idx;
        next_dq_o     = dq_o;
        next_dqs_t    = dqs_t_o;
        next_dm_o     = dmdbi_n_o;
        case (rd_state)
            RD_IDLE: begin
                next_rd_cnt = HALF_M1;
                next_dqs_t  = 2'b00;
                next_dm_o   = 2'b11;
                next_dq_o   = {12'h000, ctrl.vref_mon ? vref_level : 4'h0};      // R3
                if (rd_start) begin
                    next_rd_state = RD_PRE;
                end
            end
            RD_PRE, RD_DATA: begin
                if (tick) begin
                    if (rd_state == RD_DATA && rd_idx == 3'h7) begin
                        next_rd_state = RD_POST;
                        next_dqs_t    = 2'b00;
                    end else begin
                        next_rd_idx   = (rd_state == RD_PRE) ? 3'h0 : rd_idx + 3'h1;
                        next_rd_state = RD_DATA;
                        next_dqs_t    = {2{~next_rd_idx[0]}}; // R8
                        next_dq_o     = {enc_hi[7:0], enc_lo[7:0]} & dq_mask(ctrl.org);
                        next_dm_o     = {enc_hi[8], enc_lo[8]}; // R5
                    end
                end
            end
            RD_POST: begin
                if (tick) begin
                    next_rd_state = RD_IDLE;
                end
            end
            default: begin
                next_rd_state = RD_IDLE;
            end
        endcase
        next_dq_oe  = '0;
        next_dm_oe  = '0;
        next_dqs_oe = '0;
        if (next_rd_state == RD_DATA) begin
            next_dq_oe = dq_mask(ctrl.org); // R1
            next_dm_oe = rdbi_eff ? lane_on : 2'b00; // R6 R7
        end else if (next_rd_state == RD_IDLE && ctrl.vref_mon) begin
            next_dq_oe = {12'h000, ctrl.vref_lanes}; // R3
        end
        if (next_rd_state != RD_IDLE) begin
            next_dqs_oe = lane_on; // R9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_state   <= RD_IDLE;
            rd_cnt     <= 8'h00;
            rd_idx     <= 3'h0;
            dq_o       <= 16'h0000;
            dq_oe      <= 16'h0000;
            dqs_t_o    <= 2'b00;
            dqs_c_o    <= 2'b11;
            dqs_oe     <= 2'b00;
            dmdbi_n_o  <= 2'b11;
            dmdbi_n_oe <= 2'b00;
        end else begin
            rd_state   <= next_rd_state;
            rd_cnt     <= next_rd_cnt;
            rd_idx     <= next_rd_idx;
            dq_o       <= next_dq_o;
            dq_oe      <= next_dq_oe;
            dqs_t_o    <= next_dqs_t;
            dqs_c_o    <= ~next_dqs_t; // R10
            dqs_oe     <= next_dqs_oe;
            dmdbi_n_o  <= next_dm_o;
            dmdbi_n_oe <= next_dm_oe;
        end
    end

    // the complement termination pin is unused
    assign tdqs_c_o  = 1'b0; // R13
    assign tdqs_c_oe = 1'b0;

    // ==========
    // events, register file, alert
    always_comb begin
        events                = '0;
        events[`DLF_ST_CRC]   = ctrl.crc_en && |(lane_end & lane_bad); // R11
        events[`DLF_ST_PAR]   = ctrl.par_en && par_err; // R11
        events[`DLF_ST_STRB]  = |strb_bad;
        events[`DLF_ST_DONE]  = |lane_end;
        next_ctrl   = ctrl;
        next_mask   = mask;
        next_status = status;
        if (acc_wr && paddr == `DLF_OFS_CTRL) begin
            next_ctrl = dlf_ctrl_t'(pwdata[`DLF_CTRL_W-1:0]);
        end
        if (acc_wr && paddr == `DLF_OFS_MASK) begin
            next_mask = pwdata[`DLF_ST_W-1:0];
        end
        if (acc_wr && paddr == `DLF_OFS_STATUS) begin
            next_status = status & ~pwdata[`DLF_ST_W-1:0];
        end
        // a new event beats a clear in the same cycle
        next_status  = next_status | events;
        next_alert_n = !((next_status[`DLF_ST_CRC] && ctrl.crc_en) ||
                         (next_status[`DLF_ST_PAR] && ctrl.par_en));              // R11 R17
        next_prdata  = prdata;
        if (psel && !penable) begin
            case (paddr)
                `DLF_OFS_CTRL:   next_prdata = {18'h0_0000, ctrl};
                `DLF_OFS_STATUS: next_prdata = {28'h000_0000, status};
                `DLF_OFS_MASK:   next_prdata = {28'h000_0000, mask};
                `DLF_OFS_STATE:  next_prdata = {18'h0_0000, wl_beat[1], wl_beat[0], rd_state,
                                                wl_state[1], wl_state[0]};
                default:         next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl      <= dlf_ctrl_t'(`DLF_CTRL_RST);
            status    <= `DLF_ST_RST;
            mask      <= `DLF_MASK_RST;
            prdata    <= 32'h0000_0000;
            alert_n   <= 1'b1;
            irq       <= 1'b0;
            term_dq   <= 1'b0;
            term_dqs  <= 2'b00;
            term_tdqs <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            status    <= next_status;
            mask      <= next_mask;
            prdata    <= next_prdata;
            alert_n   <= next_alert_n;
            irq       <= |(next_status & next_mask);
            term_dq   <= s_odt && ctrl.rtt_en;
            term_dqs  <= (s_odt && ctrl.rtt_en) ? lane_on : 2'b00;
            term_tdqs <= s_odt && ctrl.rtt_en && tdqs_eff; // R12
        end
    end

endmodule

`default_nettype wire

// >>> dlf_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// lane port checker
module dlf_checker
    import dlf_pkg::*;
(
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic [1:0]      dqs_t_o,
    input wire logic [1:0]      dqs_c_o,
    input wire logic [1:0]      dqs_oe,
    input wire logic            tdqs_c_oe,
    input wire logic            rd_start,
    input wire logic            rd_take,
    input wire logic            rd_busy,
    input wire logic [15:0]     dq_oe,
    input wire logic [1:0]      dmdbi_n_oe,
    input wire dlf_beat_t [1:0] wr_beat
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_dqs_pair: assert property (dqs_c_o == ~dqs_t_o)
        else $error("strobe pair not complementary");
    a_tdqs_unused: assert property (!tdqs_c_oe)
        else $error("termination complement driven");
    a_rd_pre: assert property (rd_start && !rd_busy |=> dqs_oe[0] && !dqs_t_o[0])
        else $error("read preamble missing");
    a_take_edge: assert property (rd_take |=> $changed(dqs_t_o[0]))
        else $error("read strobe not edge aligned");
    a_take_space: assert property (rd_take |=> !rd_take [*8])
        else $error("read beats too close");
    a_beat_pulse: assert property (wr_beat[0].valid |=> !wr_beat[0].valid)
        else $error("write beat valid too long");
    a_upper_strobe: assert property (dqs_oe[1] |-> dqs_oe[0])
        else $error("upper strobe alone");
    a_wide_drive: assert property (|dq_oe[15:4] |-> rd_busy)
        else $error("upper data driven outside read");
    a_dbi_drive: assert property (dmdbi_n_oe[0] |-> dqs_oe[0])
        else $error("inversion pin driven outside read");
    c_read: cover property (rd_take);
    c_write: cover property (wr_beat[0].valid);
    c_pre: cover property (rd_start && !rd_busy);
endmodule

bind dlf_lane_top dlf_checker i_chk(.pclk, .presetn, .dqs_t_o, .dqs_c_o, .dqs_oe, .tdqs_c_oe,
    .rd_start, .rd_take, .rd_busy, .dq_oe, .dmdbi_n_oe, .wr_beat);
`default_nettype wire

// >>> dlf_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// controller write side; strobe stands low between bursts
module dlf_ctl_model (
    output var logic [1:0]  dqs_t,
    output var logic [1:0]  dqs_c,
    output var logic [15:0] dq,
    output var logic [1:0]  dm_n
);
    initial begin
        {dqs_t, dqs_c, dq, dm_n} = {2'h0, 2'h3, 16'h0000, 2'h3};
    end
    // data leads the strobe by a quarter period so each edge lands mid window
    task automatic burst(input logic [7:0] b, input logic [7:0] m);
        #2; // off the pclk edge
        for (int i = 0; i < 8; i++) begin
            dq = {2{b + 8'(i)}};
            dm_n = {2{m[i]}};
            #40;
            dqs_t = ~dqs_t;
            dqs_c = ~dqs_t;
            #40;
        end
        // released lines show the inverse
        dq = ~dq;
        dm_n = ~dm_n;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dlf_defs.svh"
// ==========
// lane bench
module tb;
    import dlf_pkg::*;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic            odt, wr_start, par_err, rd_start, rd_take, rd_busy, alert_n, term_tdqs;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, r;
    logic [15:0]     dq_i, dq_o, dq_oe, m_dq, rd_data;
    logic [1:0]      dqs_t_i, dqs_c_i, dqs_t_o, dqs_c_o, dqs_oe, m_t, m_c;
    logic [1:0]      dmdbi_n_i, dmdbi_n_o, dmdbi_n_oe, m_dm;
    dlf_beat_t [1:0] wr_beat;
    logic [8:0]      q[$];
    int              miscompares, n_tests, cyc;
    assign dq_i = (dq_o & dq_oe) | (m_dq & ~dq_oe);
    assign dqs_t_i = (dqs_t_o & dqs_oe) | (m_t & ~dqs_oe);
    assign dqs_c_i = (dqs_c_o & dqs_oe) | (m_c & ~dqs_oe);
    assign dmdbi_n_i = (dmdbi_n_o & dmdbi_n_oe) | (m_dm & ~dmdbi_n_oe);
    dlf_lane_top i_dlf_lane_top(.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .irq, .dq_i, .dq_o, .dq_oe, .dqs_t_i, .dqs_c_i, .dqs_t_o, .dqs_c_o, .dqs_oe,
        .dmdbi_n_i, .dmdbi_n_o, .dmdbi_n_oe, .tdqs_c_o(), .tdqs_c_oe(), .alert_n, .odt, .term_dq(),
        .term_dqs(), .term_tdqs, .wr_start, .par_err, .vref_level(rd_data[3:0]), .wr_beat, .rd_start,
        .rd_data, .rd_take, .rd_busy);
    dlf_ctl_model i_ctl(.dqs_t(m_t), .dqs_c(m_c), .dq(m_dq), .dm_n(m_dm));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(negedge pclk) if (wr_beat[0].valid === 1'b1) q.push_back({wr_beat[0].be, wr_beat[0].data});
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("tests %0d errors %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("Error at %0t: got %h exp %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic t_regs;
        apb(0, `DLF_OFS_CTRL, 0);
        chk(r, 32'h0000_0000);
        apb(1, `DLF_OFS_CTRL, 32'h0000_0011);
        apb(0, `DLF_OFS_CTRL, 0);
        chk(r, 32'h0000_0011);
        apb(0, 8'h10, 0);
        chk({r[30:0], e}, 32'h0000_0001);
    endtask
    task automatic t_write;
        @(posedge pclk);
        wr_start <= 1'b1;
        @(posedge pclk);
        wr_start <= 1'b0;
        i_ctl.burst(8'h30, 8'hfd);
        repeat (8) @(posedge pclk);
        chk(32'(q.size()), 32'h0000_0008);
        for (int i = 0; i < 8; i++) chk(32'(q[i]), {23'h0, 1'(i != 1), 8'h30 + 8'(i)});
        apb(0, `DLF_OFS_STATUS, 0);
        chk(r, 32'h0000_0008);
        apb(1, `DLF_OFS_MASK, 32'h0000_0008);
        @(posedge pclk);
        #1 chk(32'(irq), 32'h0000_0001);
        apb(1, `DLF_OFS_STATUS, 32'h0000_0008);
        @(posedge pclk);
        #1 chk(32'(irq), 32'h0000_0000);
    endtask
    task automatic t_read;
        apb(1, `DLF_OFS_CTRL, 32'h0000_0009);
        @(posedge pclk);
        {rd_data, rd_start} <= {16'h0001, 1'b1};
        @(posedge pclk);
        rd_start <= 1'b0;
        do begin @(posedge pclk); #1; end while (rd_take !== 1'b1);
        @(posedge pclk);
        #1 chk(32'(dq_o[7:0]), 32'h0000_00fe);
        chk(32'(dmdbi_n_o[0]), 32'h0000_0000);
        while (rd_busy !== 1'b0) @(posedge pclk);
    endtask
    task automatic t_vref;
        rd_data <= 16'h000a;
        apb(1, `DLF_OFS_CTRL, 32'h0000_1501);
        @(posedge pclk);
        #1 chk({dq_oe, dq_o}, 32'h0005_000a);
        apb(1, `DLF_OFS_CTRL, 32'h0000_0221);
        odt <= 1'b1;
        repeat (4) @(posedge pclk);
        #1 chk(32'(term_tdqs), 32'h0000_0001);
    endtask
    task automatic t_alert;
        apb(1, `DLF_OFS_CTRL, 32'h0000_0081);
        @(posedge pclk);
        par_err <= 1'b1;
        @(posedge pclk);
        par_err <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 chk(32'(alert_n), 32'h0000_0000);
        apb(1, `DLF_OFS_STATUS, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        #1 chk(32'(alert_n), 32'h0000_0001);
    endtask
    initial begin
        {psel, penable, pwrite, odt, wr_start, par_err, rd_start, presetn} = 8'h00;
        {paddr, pwdata, rd_data} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_write;
        t_read;
        t_vref;
        t_alert;
        report_and_stop;
    end
endmodule
`default_nettype wire
